/* hw/rao_cfg.svh */
// constants for the radar sample serial output block
`ifndef RAO_CFG_SVH
`define RAO_CFG_SVH

`define RAO_LANES 4
`define RAO_SAMPLE_W 12
`define RAO_WORD_W 48
`define RAO_SYNC_BYTE 8'hb8
`define RAO_SYNC_LAST 4'h7
`define RAO_WORD_LAST 4'hb
`define RAO_WORD_END 4'hc

// register byte addresses
`define RAO_ADDR_CTRL 8'h00
`define RAO_ADDR_LANE 8'h04
`define RAO_ADDR_RATE 8'h08
`define RAO_ADDR_STATUS 8'h0c

// field positions and reset values
`define RAO_CTRL_CSI_EN 0
`define RAO_CTRL_DBG_EN 1
`define RAO_LANE_ROLE_LSB 0
`define RAO_LANE_POL_LSB 4
`define RAO_RATE_CSI_LSB 0
`define RAO_RATE_DBG_LSB 16
`define RAO_ROLE_RST 4'h1
`define RAO_CSI_RATE_RST 10'h258
`define RAO_CSI_RATE_MIN 10'h096
`define RAO_CSI_RATE_MAX 10'h258

// debug port reference ticks per bit: 900,600,450,400,300,225,150 Mbps
`define RAO_DBG_DIV_0 5'd4
`define RAO_DBG_DIV_1 5'd6
`define RAO_DBG_DIV_2 5'd8
`define RAO_DBG_DIV_3 5'd9
`define RAO_DBG_DIV_4 5'd12
`define RAO_DBG_DIV_5 5'd16
`define RAO_DBG_DIV_6 5'd24

// link timing; one link clock period is one unit interval
`define RAO_UI_NS 12
`define RAO_CYC_UP(ns) (((ns) + `RAO_UI_NS - 1) / `RAO_UI_NS)
`define RAO_MAX(a, b) (((a) > (b)) ? (a) : (b))
`define RAO_LPX_NS 50
`define RAO_CLK_PREP_NS 38
`define RAO_CLK_PREP_ZERO_NS 300
`define RAO_CLK_PRE_NS 8
`define RAO_HS_PREP_NS (40 + 4 * `RAO_UI_NS)
`define RAO_HS_PREP_ZERO_NS (145 + 10 * `RAO_UI_NS)
`define RAO_HS_TRAIL_NS `RAO_MAX(8 * `RAO_UI_NS, 60 + 4 * `RAO_UI_NS)
`define RAO_HS_EXIT_NS 100
`define RAO_LPX_CYC `RAO_CYC_UP(`RAO_LPX_NS)
`define RAO_CLK_PREP_CYC `RAO_CYC_UP(`RAO_MAX(`RAO_CLK_PREP_NS, `RAO_LPX_NS))
`define RAO_CLK_ZERO_CYC (`RAO_CYC_UP(`RAO_CLK_PREP_ZERO_NS) - `RAO_CLK_PREP_CYC)
`define RAO_CLK_PRE_CYC `RAO_CYC_UP(`RAO_CLK_PRE_NS)
`define RAO_HS_PREP_CYC `RAO_CYC_UP(`RAO_MAX(`RAO_HS_PREP_NS, `RAO_LPX_NS))
`define RAO_HS_ZERO_CYC (`RAO_CYC_UP(`RAO_HS_PREP_ZERO_NS) - `RAO_HS_PREP_CYC)
`define RAO_HS_TRAIL_CYC `RAO_CYC_UP(`RAO_HS_TRAIL_NS)
`define RAO_HS_EXIT_CYC `RAO_CYC_UP(`RAO_HS_EXIT_NS)

`endif

/* hw/rao_pkg.sv */
// state types of the radar sample serial output block
package rao_pkg;

    typedef enum logic [2:0] {
        CK_OFF  = 3'b000,
        CK_LPX  = 3'b001,
        CK_PREP = 3'b010,
        CK_ZERO = 3'b011,
        CK_RUN  = 3'b100
    } rao_ck_e;

    typedef enum logic [2:0] {
        DL_IDLE  = 3'b000,
        DL_LPX   = 3'b001,
        DL_PREP  = 3'b010,
        DL_ZERO  = 3'b011,
        DL_SYNC  = 3'b100,
        DL_PAY   = 3'b101,
        DL_TRAIL = 3'b110,
        DL_EXIT  = 3'b111
    } rao_dl_e;

endpackage

/* hw/rao_serial_out.sv */
// radar sample output: camera-serial lanes and debug lvds lanes
//
// Our own choices: the placing of the registers and the plain strobed port.
`include "rao_cfg.svh"

module rao_serial_out import rao_pkg::*; (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic link_clk,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [47:0] sample_word,
    input wire logic sample_valid,
    output logic sample_ready,
    output logic [3:0] csi_lane_lp_p,
    output logic [3:0] csi_lane_lp_n,
    output logic [3:0] csi_lane_hs_en,
    output logic [3:0] csi_lane_hs_bit,
    output logic [3:0] debug_data_lane_pair,
    output logic debug_bit_clock_pair,
    output logic debug_frame_clock_pair
);

    // ---------------- core clock domain ----------------
    logic [1:0] ctrl_r;
    logic [3:0] lane_role_r;
    logic [3:0] lane_pol_r;
    logic [9:0] csi_rate_r;
    logic [2:0] dbg_rate_r;
    logic [31:0] rdata_r;
    logic [47:0] word_hold_r;
    logic req_tog_r;
    logic ready_r;
    logic [2:0] ack_sync_r;
    logic ack_seen_r;
    logic [1:0] st_s1_r;
    logic [1:0] st_s2_r;
    logic [1:0] st_s3_r;
    logic [1:0] st_seen_r;
    logic lk_ack_r;
    logic [1:0] lk_status_r;
    logic rate_ok;
    logic role_ok;
    logic [12:0] cfg_core;

    assign rate_ok = (csi_rate_r >= `RAO_CSI_RATE_MIN) &&
                     (csi_rate_r <= `RAO_CSI_RATE_MAX);
    // exactly one lane may be the clock lane
    assign role_ok = (lane_role_r != 4'h0) &&
                     ((lane_role_r & (lane_role_r - 4'h1)) == 4'h0);
    assign cfg_core = {dbg_rate_r, lane_pol_r, lane_role_r,
                       ctrl_r[`RAO_CTRL_DBG_EN],
                       ctrl_r[`RAO_CTRL_CSI_EN] & rate_ok & role_ok};

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= 2'h0;
            lane_role_r <= `RAO_ROLE_RST;
            lane_pol_r <= 4'h0;
            csi_rate_r <= `RAO_CSI_RATE_RST;
            dbg_rate_r <= 3'h0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `RAO_ADDR_CTRL: ctrl_r <= reg_wdata[1:0];
                `RAO_ADDR_LANE: begin
                    lane_role_r <= reg_wdata[`RAO_LANE_ROLE_LSB +: 4];
                    lane_pol_r <= reg_wdata[`RAO_LANE_POL_LSB +: 4];
                end
                `RAO_ADDR_RATE: begin
                    csi_rate_r <= reg_wdata[`RAO_RATE_CSI_LSB +: 10];
                    // code 7 is not a rate; it is held at the slowest one
                    dbg_rate_r <= (reg_wdata[`RAO_RATE_DBG_LSB +: 3] == 3'h7)
                        ? 3'h6 : reg_wdata[`RAO_RATE_DBG_LSB +: 3];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= 32'h0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `RAO_ADDR_CTRL: rdata_r <= {30'h0, ctrl_r};
                `RAO_ADDR_LANE: rdata_r <= {24'h0, lane_pol_r, lane_role_r};
                `RAO_ADDR_RATE: rdata_r <= {13'h0, dbg_rate_r, 6'h0,
                                            csi_rate_r};
                `RAO_ADDR_STATUS: rdata_r <= {27'h0, ready_r, role_ok,
                                              rate_ok, st_seen_r};
                default: rdata_r <= 32'h0;
            endcase
        end else begin
            rdata_r <= 32'h0;
        end
    end

    // sample word handshake: the hold register stays still until acked
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            word_hold_r <= 48'h0;
            req_tog_r <= 1'b0;
            ready_r <= 1'b0;
        end else if (sample_valid && ready_r) begin
            word_hold_r <= sample_word;
            req_tog_r <= ~req_tog_r;
            ready_r <= 1'b0;
        end else begin
            ready_r <= (ack_seen_r == req_tog_r);
        end
    end

    // link to core: three flops, a change counts once stages 2 and 3 agree
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ack_sync_r <= 3'h0;
            ack_seen_r <= 1'b0;
            st_s1_r <= 2'h0;
            st_s2_r <= 2'h0;
            st_s3_r <= 2'h0;
            st_seen_r <= 2'h0;
        end else begin
            ack_sync_r <= {ack_sync_r[1:0], lk_ack_r};
            if (ack_sync_r[1] == ack_sync_r[2]) begin
                ack_seen_r <= ack_sync_r[2];
            end
            st_s1_r <= lk_status_r;
            st_s2_r <= st_s1_r;
            st_s3_r <= st_s2_r;
            st_seen_r <= (st_s2_r & st_s3_r) |
                         (st_seen_r & (st_s2_r ^ st_s3_r));
        end
    end

    assign reg_rdata = rdata_r;
    assign sample_ready = ready_r;

    // ---------------- link clock domain ----------------
    logic lk_rst_q_r;
    logic lk_rst_b;
    logic [12:0] cfg_s1_r;
    logic [12:0] cfg_s2_r;
    logic [12:0] cfg_s3_r;
    logic [12:0] lk_cfg_r;
    logic [2:0] req_sync_r;
    logic lk_req_r;
    logic lk_taken_r;
    logic [47:0] lk_word_r;
    logic csi_pend_r;
    logic dbg_pend_r;
    rao_ck_e ck_state_r;
    logic [5:0] ck_cnt_r;
    logic ck_tog_r;
    rao_dl_e dl_state_r;
    logic [5:0] dl_cnt_r;
    logic [3:0] dl_idx_r;
    logic dbg_busy_r;
    logic [4:0] dbg_div_r;
    logic [3:0] dbg_idx_r;
    logic [4:0] dbg_div;
    logic lk_csi_on;
    logic lk_dbg_on;
    logic [3:0] lk_role;
    logic [3:0] lk_pol;
    logic [2:0] lk_dbg_rate;
    logic clk_ready;
    logic csi_done;
    logic dbg_tick;
    logic dbg_done;

    assign {lk_dbg_rate, lk_pol, lk_role, lk_dbg_on, lk_csi_on} = lk_cfg_r;
    assign clk_ready = (ck_state_r == CK_RUN) &&
                       (ck_cnt_r >= 6'(`RAO_CLK_PRE_CYC));
    assign csi_done = (dl_state_r == DL_TRAIL) && (dl_cnt_r == 6'h0);
    assign dbg_tick = dbg_busy_r && (dbg_div_r == 5'h0);
    assign dbg_done = dbg_tick && (dbg_idx_r == `RAO_WORD_END);

    // release of the link reset is brought onto the link clock
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            lk_rst_q_r <= 1'b0;
            lk_rst_b <= 1'b0;
        end else begin
            lk_rst_q_r <= 1'b1;
            lk_rst_b <= lk_rst_q_r;
        end
    end

    // config is quasi-static; change it only while both ports are off
    always_ff @(posedge link_clk or negedge lk_rst_b) begin
        if (!lk_rst_b) begin
            cfg_s1_r <= 13'h0;
            cfg_s2_r <= 13'h0;
            cfg_s3_r <= 13'h0;
            lk_cfg_r <= 13'h0;
            req_sync_r <= 3'h0;
            lk_req_r <= 1'b0;
        end else begin
            cfg_s1_r <= cfg_core;
            cfg_s2_r <= cfg_s1_r;
            cfg_s3_r <= cfg_s2_r;
            lk_cfg_r <= (cfg_s2_r & cfg_s3_r) |
                        (lk_cfg_r & (cfg_s2_r ^ cfg_s3_r));
            req_sync_r <= {req_sync_r[1:0], req_tog_r};
            if (req_sync_r[1] == req_sync_r[2]) begin
                lk_req_r <= req_sync_r[2];
            end
        end
    end

    // word capture; ack goes back once every enabled port has sent it
    always_ff @(posedge link_clk or negedge lk_rst_b) begin
        if (!lk_rst_b) begin
            lk_ack_r <= 1'b0;
            lk_taken_r <= 1'b0;
            lk_word_r <= 48'h0;
            csi_pend_r <= 1'b0;
            dbg_pend_r <= 1'b0;
            lk_status_r <= 2'h0;
        end else begin
            lk_status_r <= {csi_pend_r | dbg_pend_r, ck_state_r == CK_RUN};
            if (lk_req_r != lk_ack_r && !lk_taken_r) begin
                lk_word_r <= word_hold_r;
                lk_taken_r <= 1'b1;
                csi_pend_r <= lk_csi_on;
                dbg_pend_r <= lk_dbg_on;
            end else begin
                if (lk_taken_r && !csi_pend_r && !dbg_pend_r) begin
                    lk_ack_r <= ~lk_ack_r;
                    lk_taken_r <= 1'b0;
                end
                if (csi_done || !lk_csi_on) begin
                    csi_pend_r <= 1'b0;
                end
                if (dbg_done || !lk_dbg_on) begin
                    dbg_pend_r <= 1'b0;
                end
            end
        end
    end

    // clock lane start-up, then free running high speed
    always_ff @(posedge link_clk or negedge lk_rst_b) begin
        if (!lk_rst_b) begin
            ck_state_r <= CK_OFF;
            ck_cnt_r <= 6'h0;
            ck_tog_r <= 1'b0;
        end else if (!lk_csi_on) begin
            ck_state_r <= CK_OFF;
            ck_cnt_r <= 6'h0;
            ck_tog_r <= 1'b0;
        end else begin
            if (ck_cnt_r != 6'h0 && ck_state_r != CK_RUN) begin
                ck_cnt_r <= ck_cnt_r - 6'h1;
            end
            unique case (ck_state_r)
                CK_OFF: begin
                    ck_state_r <= CK_LPX;
                    ck_cnt_r <= 6'(`RAO_LPX_CYC - 1);
                end
                CK_LPX: if (ck_cnt_r == 6'h0) begin
                    ck_state_r <= CK_PREP;
                    ck_cnt_r <= 6'(`RAO_CLK_PREP_CYC - 1);
                end
                CK_PREP: if (ck_cnt_r == 6'h0) begin
                    ck_state_r <= CK_ZERO;
                    ck_cnt_r <= 6'(`RAO_CLK_ZERO_CYC - 1);
                end
                CK_ZERO: if (ck_cnt_r == 6'h0) begin
                    ck_state_r <= CK_RUN;
                end
                CK_RUN: begin
                    // never leaves high speed while enabled
                    ck_tog_r <= ~ck_tog_r;
                    if (ck_cnt_r < 6'(`RAO_CLK_PRE_CYC)) begin
                        ck_cnt_r <= ck_cnt_r + 6'h1;
                    end
                end
                default: ck_state_r <= CK_OFF;
            endcase
        end
    end

    // data lane burst: entry, sync byte, payload, trail, exit
    always_ff @(posedge link_clk or negedge lk_rst_b) begin
        if (!lk_rst_b) begin
            dl_state_r <= DL_IDLE;
            dl_cnt_r <= 6'h0;
            dl_idx_r <= 4'h0;
        end else if (!lk_csi_on) begin
            dl_state_r <= DL_IDLE;
            dl_cnt_r <= 6'h0;
            dl_idx_r <= 4'h0;
        end else begin
            if (dl_cnt_r != 6'h0) begin
                dl_cnt_r <= dl_cnt_r - 6'h1;
            end
            unique case (dl_state_r)
                DL_IDLE: if (csi_pend_r && clk_ready) begin
                    dl_state_r <= DL_LPX;
                    dl_cnt_r <= 6'(`RAO_LPX_CYC - 1);
                end
                DL_LPX: if (dl_cnt_r == 6'h0) begin
                    dl_state_r <= DL_PREP;
                    dl_cnt_r <= 6'(`RAO_HS_PREP_CYC - 1);
                end
                DL_PREP: if (dl_cnt_r == 6'h0) begin
                    dl_state_r <= DL_ZERO;
                    dl_cnt_r <= 6'(`RAO_HS_ZERO_CYC - 1);
                end
                DL_ZERO: if (dl_cnt_r == 6'h0) begin
                    dl_state_r <= DL_SYNC;
                    dl_idx_r <= 4'h0;
                end
                DL_SYNC: begin
                    dl_idx_r <= (dl_idx_r == `RAO_SYNC_LAST) ? 4'h0
                                                             : dl_idx_r + 4'h1;
                    if (dl_idx_r == `RAO_SYNC_LAST) begin
                        dl_state_r <= DL_PAY;
                    end
                end
                DL_PAY: begin
                    dl_idx_r <= dl_idx_r + 4'h1;
                    if (dl_idx_r == `RAO_WORD_LAST) begin
                        dl_state_r <= DL_TRAIL;
                        dl_cnt_r <= 6'(`RAO_HS_TRAIL_CYC - 1);
                    end
                end
                DL_TRAIL: if (dl_cnt_r == 6'h0) begin
                    // lp-11 follows the trail at once
                    dl_state_r <= DL_EXIT;
                    dl_cnt_r <= 6'(`RAO_HS_EXIT_CYC - 1);
                end
                DL_EXIT: if (dl_cnt_r == 6'h0) begin
                    dl_state_r <= DL_IDLE;
                end
                default: dl_state_r <= DL_IDLE;
            endcase
        end
    end

    // per lane line state; swap exchanges the wires of the pair
    logic [3:0] lane_p_r;
    logic [3:0] lane_n_r;
    logic [3:0] lane_hs_r;
    logic [3:0] lane_bit_r;
    logic [3:0] dbg_lane_r;

    for (genvar i = 0; i < `RAO_LANES; i++) begin : g_lane
        logic [11:0] lane_word;
        logic [7:0] sync_byte;
        logic [1:0] lp;
        logic hs_en;
        logic hs_bit;

        assign lane_word = lk_word_r[i * `RAO_SAMPLE_W +: `RAO_SAMPLE_W];
        assign sync_byte = `RAO_SYNC_BYTE;

        always_comb begin
            lp = 2'b11;
            hs_en = 1'b0;
            hs_bit = 1'b0;
            if (lk_role[i]) begin
                unique case (ck_state_r)
                    CK_LPX: lp = 2'b01;
                    CK_PREP: lp = 2'b00;
                    CK_ZERO: hs_en = 1'b1;
                    CK_RUN: begin
                        hs_en = 1'b1;
                        hs_bit = ck_tog_r;
                    end
                    default: lp = 2'b11;
                endcase
            end else begin
                unique case (dl_state_r)
                    DL_LPX: lp = 2'b01;
                    DL_PREP: lp = 2'b00;
                    DL_ZERO: hs_en = 1'b1;
                    DL_SYNC: begin
                        hs_en = 1'b1;
                        hs_bit = sync_byte[dl_idx_r[2:0]];
                    end
                    DL_PAY: begin
                        hs_en = 1'b1;
                        hs_bit = lane_word[dl_idx_r];
                    end
                    DL_TRAIL: begin
                        hs_en = 1'b1;
                        hs_bit = ~lane_word[`RAO_WORD_LAST];
                    end
                    default: lp = 2'b11;
                endcase
            end
        end

        always_ff @(posedge link_clk or negedge lk_rst_b) begin
            if (!lk_rst_b) begin
                lane_p_r[i] <= 1'b1;
                lane_n_r[i] <= 1'b1;
                lane_hs_r[i] <= 1'b0;
                lane_bit_r[i] <= 1'b0;
                dbg_lane_r[i] <= 1'b0;
            end else begin
                lane_p_r[i] <= lk_pol[i] ? lp[0] : lp[1];
                lane_n_r[i] <= lk_pol[i] ? lp[1] : lp[0];
                lane_hs_r[i] <= hs_en;
                lane_bit_r[i] <= hs_bit ^ lk_pol[i];
                if (dbg_tick && dbg_idx_r != `RAO_WORD_END) begin
                    dbg_lane_r[i] <= lane_word[dbg_idx_r];
                end
            end
        end
    end

    // debug port bit period in reference ticks of the link clock
    always_comb begin
        unique case (lk_dbg_rate)
            3'h0: dbg_div = `RAO_DBG_DIV_0;
            3'h1: dbg_div = `RAO_DBG_DIV_1;
            3'h2: dbg_div = `RAO_DBG_DIV_2;
            3'h3: dbg_div = `RAO_DBG_DIV_3;
            3'h4: dbg_div = `RAO_DBG_DIV_4;
            3'h5: dbg_div = `RAO_DBG_DIV_5;
            default: dbg_div = `RAO_DBG_DIV_6;
        endcase
    end

    logic dbg_bclk_r;
    logic dbg_fclk_r;

    always_ff @(posedge link_clk or negedge lk_rst_b) begin
        if (!lk_rst_b) begin
            dbg_busy_r <= 1'b0;
            dbg_div_r <= 5'h0;
            dbg_idx_r <= 4'h0;
            dbg_bclk_r <= 1'b0;
            dbg_fclk_r <= 1'b0;
        end else if (!lk_dbg_on || dbg_done) begin
            dbg_busy_r <= 1'b0;
        end else if (!dbg_busy_r) begin
            if (dbg_pend_r) begin
                dbg_busy_r <= 1'b1;
                dbg_div_r <= 5'h0;
                dbg_idx_r <= 4'h0;
                dbg_fclk_r <= ~dbg_fclk_r;
            end
        end else if (dbg_tick) begin
            dbg_div_r <= dbg_div - 5'h1;
            dbg_idx_r <= dbg_idx_r + 4'h1;
            dbg_bclk_r <= ~dbg_bclk_r;
        end else begin
            dbg_div_r <= dbg_div_r - 5'h1;
        end
    end

    assign csi_lane_lp_p = lane_p_r;
    assign csi_lane_lp_n = lane_n_r;
    assign csi_lane_hs_en = lane_hs_r;
    assign csi_lane_hs_bit = lane_bit_r;
    assign debug_data_lane_pair = dbg_lane_r;
    assign debug_bit_clock_pair = dbg_bclk_r;
    assign debug_frame_clock_pair = dbg_fclk_r;

endmodule

/* testbench/rao_csi_rx_model.sv */
// receiving end of the camera-serial data lanes 1 to 3
module rao_csi_rx_model (
    input wire logic link_clk,
    input wire logic [3:0] hs_en,
    input wire logic [3:0] hs_bit,
    input wire logic [3:0] pol,
    output logic [35:0] word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh [1:3];
    int n [1:3];
    // the pair is read as wired, so a configured swap is undone here
    always @(posedge link_clk) begin
        for (int i = 1; i < 4; i++) begin
            logic b;
            b = hs_bit[i] ^ pol[i];
            if (!hs_en[i]) begin
                sh[i] = 8'h00;
                n[i] = -1;
            end else if (n[i] < 0) begin
                sh[i] = {b, sh[i][7:1]};
                if (sh[i] == 8'hb8) n[i] = 0;
            end else if (n[i] < 12) begin
                word[(i - 1) * 12 + n[i]] = b;
                n[i]++;
            end
        end
    end
endmodule

/* testbench/rao_serial_out_checker.sv */
// link-side timing checks of the camera-serial lanes
module rao_serial_out_checker (
    input logic link_clk,
    input logic rst_b,
    input logic [3:0] csi_lane_lp_p,
    input logic [3:0] csi_lane_lp_n,
    input logic [3:0] csi_lane_hs_en,
    input logic [3:0] csi_lane_hs_bit
);
    timeunit 1ns;
    timeprecision 1ps;
    wire [3:0] p = csi_lane_lp_p;
    wire [3:0] n = csi_lane_lp_n;
    wire [3:0] e = csi_lane_hs_en;
    wire [3:0] b = csi_lane_hs_bit;
    wire z0 = !e[0] && !p[0] && !n[0];
    wire z1 = !e[1] && !p[1] && !n[1];
    wire c1 = !e[1] && !p[1] && n[1];
    wire s1 = !e[1] && p[1] && n[1];
    default clocking @(posedge link_clk); endclocking
    default disable iff (!rst_b);
    chk_lp01_len: assert property (c1 && $past(p[1]) |-> c1[*5] ##1 z1)
        else $error("low-power request state length wrong");
    chk_clk_prep: assert property (z0 && $past(n[0]) |-> z0[*5] ##1 e[0])
        else $error("clock lane prepare length wrong");
    chk_data_prep: assert property (z1 && $past(n[1]) |-> z1[*8] ##1 e[1])
        else $error("data lane prepare length wrong");
    chk_clk_zero: assert property ($rose(e[0]) |->
        (!b[0])[*8] ##13 !b[0] ##1 b[0])
        else $error("clock lane zero period wrong");
    chk_clk_toggle: assert property (e[0] && $past(e[0]) &&
        b[0] != $past(b[0]) |=> e[0] && b[0] != $past(b[0]))
        else $error("clock lane stopped toggling");
    chk_clk_first: assert property ($fell(p[1]) |-> e[0] && $past(e[0]))
        else $error("data entry before clock running");
    chk_data_sync: assert property ($rose(e[1]) |-> (!b[1])[*8]
        ##11 b[1] ##1 b[1] ##1 b[1] ##1 !b[1] ##1 b[1])
        else $error("zero period or sync byte wrong");
    chk_trail_exit: assert property ($rose(e[1]) |-> ##35
        b[1] != $past(b[1]) ##1 $stable(b[1])[*8] ##1 s1)
        else $error("trail or return to stop state wrong");
    chk_exit_hold: assert property ($fell(e[1]) |-> s1[*8] ##1 s1)
        else $error("stop state too short after burst");
endmodule

bind rao_serial_out rao_serial_out_checker u_chk (.link_clk(link_clk),
    .rst_b(rst_b), .csi_lane_lp_p(csi_lane_lp_p),
    .csi_lane_lp_n(csi_lane_lp_n), .csi_lane_hs_en(csi_lane_hs_en),
    .csi_lane_hs_bit(csi_lane_hs_bit));

/* testbench/tb_top.sv */
// testbench of the radar sample serial output
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic link_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [47:0] sample_word = 48'h0;
    logic sample_valid = 1'b0;
    logic sample_ready;
    logic [3:0] lp_p, lp_n, hs_en, hs_bit, dbg_d;
    logic [3:0] pol = 4'h0;
    logic dbg_bc, dbg_fc, bc_q, fc_q;
    logic [35:0] rx_word;
    logic [47:0] dsh;
    int bad_count = 0, n_compared = 0, cyc = 0, gap = 0, last_gap = 0;
    int bit_n = 0, frm_n = 0;
    int dv[7] = '{4, 6, 8, 9, 12, 16, 24};
    always #5 clock = ~clock;
    initial begin
        #2.7;
        forever #6 link_clk = ~link_clk;
    end
    rao_serial_out dut (.clock(clock), .rst_b(rst_b), .link_clk(link_clk),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_word(sample_word),
        .sample_valid(sample_valid), .sample_ready(sample_ready),
        .csi_lane_lp_p(lp_p), .csi_lane_lp_n(lp_n), .csi_lane_hs_en(hs_en),
        .csi_lane_hs_bit(hs_bit), .debug_data_lane_pair(dbg_d),
        .debug_bit_clock_pair(dbg_bc), .debug_frame_clock_pair(dbg_fc));
    rao_csi_rx_model rx (.link_clk(link_clk), .hs_en(hs_en),
        .hs_bit(hs_bit), .pol(pol), .word(rx_word));
    // debug clock edges are counted in link cycles, the unit of the divider
    always @(posedge link_clk) begin
        gap++;
        if (dbg_bc !== bc_q) begin
            last_gap = gap;
            gap = 0;
            bit_n++;
            // data lanes change with the bit clock, so read them here
            for (int i = 0; i < 4; i++)
                dsh[i * 12 +: 12] = {dbg_d[i], dsh[i * 12 + 1 +: 11]};
        end
        if (dbg_fc !== fc_q) frm_n++;
        bc_q = dbg_bc;
        fc_q = dbg_fc;
    end
    task automatic chk(input string what, input logic [47:0] exp,
        input logic [47:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        chk("read data", {4'h0, e}, {4'h0, reg_rdata});
    endtask
    task automatic send(input logic [47:0] w);
        @(posedge clock);
        sample_word <= w;
        sample_valid <= 1'b1;
        do @(posedge clock); while (sample_ready !== 1'b1);
        sample_valid <= 1'b0;
        repeat (2) @(posedge clock);
        for (int t = 0; t < 3000 && sample_ready !== 1'b1; t++)
            @(posedge clock);
    endtask
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            summarize();
        end
    end
    initial begin
        logic [47:0] w;
        int b0, f0;
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        rd(8'h04, 32'h1);
        rd(8'h08, 32'h258);
        rd(8'h00, 32'h0);
        rd(8'h10, 32'h0);
        wr(8'h0c, 32'h0);
        rd(8'h0c, 32'h1c);
        wr(8'h04, 32'h3);
        rd(8'h0c, 32'h14);
        wr(8'h04, 32'h41);
        wr(8'h08, 32'h95);
        rd(8'h0c, 32'h18);
        wr(8'h08, 32'h259);
        rd(8'h0c, 32'h18);
        wr(8'h08, 32'h96);
        rd(8'h0c, 32'h1c);
        wr(8'h08, 32'h70258);
        rd(8'h08, 32'h60258);
        $display("test registers done");
        pol <= 4'h4;
        wr(8'h00, 32'h1);
        repeat (60) @(posedge clock);
        rd(8'h0c, 32'h1d);
        w = 48'h5a3c71e08000;
        send(w);
        chk("csi word", w[47:12], rx_word);
        w = 48'ha5c38e1f7000;
        send(w);
        chk("csi word", w[47:12], rx_word);
        $display("test csi done");
        for (int r = 0; r < 7; r++) begin
            wr(8'h00, 32'h1);
            wr(8'h08, {13'h0, r[2:0], 16'h0258});
            wr(8'h00, 32'h3);
            w = 48'h9e37b4c15a2d + 48'h111111111111 * r;
            b0 = bit_n;
            f0 = frm_n;
            send(w);
            chk("bit gap", dv[r], last_gap);
            chk("bit edges", 12, bit_n - b0);
            chk("frame edges", 1, frm_n - f0);
            chk("debug word", w, dsh);
            chk("csi word", w[47:12], rx_word);
            $display("test debug rate %0d done", r);
        end
        summarize();
    end
endmodule
